// ==== verilog/dbl_defs.vh ====
// dbl_defs.vh: offsets, field positions, reset values and counts for the dead-band/lfsr block
// assumes: included by the design files of the dbl block only
`ifndef DBL_DEFS_VH
`define DBL_DEFS_VH

// register byte addresses on apb
`define DBL_OFF_COUNT_STATE 12'h000
`define DBL_OFF_PERIOD_POLY 12'h004
`define DBL_OFF_COMPARE_SEED 12'h008
`define DBL_OFF_CONTROL 12'h00c
`define DBL_OFF_IRQ_STATUS 12'h010
`define DBL_OFF_IRQ_MASK 12'h014
`define DBL_OFF_STATUS 12'h018

// control register fields
`define DBL_CTL_ENABLE 0
`define DBL_CTL_MODE 1
`define DBL_CTL_CMP_LO 2
`define DBL_CTL_CMP_HI 3
`define DBL_CTL_WIDTH 4

// compare types
`define DBL_CMP_EQ 2'h0
`define DBL_CMP_LE 2'h1
`define DBL_CMP_LT 2'h2
`define DBL_CMP_NE 2'h3

// interrupt status bits
`define DBL_IRQ_TC 0
`define DBL_IRQ_CMP 1
`define DBL_IRQ_WIDTH 2

// reset values
`define DBL_RST_BYTE 8'h00
`define DBL_RST_CTL 4'h0
`define DBL_RST_IRQ 2'h0

// apb response timing: one wait-free access phase
`define DBL_ACCESS_CYCLES 1

`endif

// ==== verilog/dbl_down_counter.v ====
// dbl_down_counter.v: dead-band down counter with reload on terminal count
// assumes: same clock as the register file; load pulses come from bus logic
`timescale 1ns/1ps
module dbl_down_counter (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire run,
  input wire load,
  input wire [7:0] load_value,
  input wire [7:0] period,
  // state
  output reg [7:0] count_reg,
  output wire terminal_count
);
  `include "dbl_defs.vh"

  reg [7:0] count_next;

  // zero count ends one pass of period plus one clocks
  assign terminal_count = run && (count_reg == 8'h00);

  // next count: bus load, reload after terminal count, else decrement
  always @* begin
    count_next = count_reg;
    if (load) begin
      count_next = load_value;
    end else if (run) begin
      if (count_reg == 8'h00) begin
        count_next = period;
      end else begin
        count_next = count_reg - 8'h01;
      end
    end
  end

  // count state register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= `DBL_RST_BYTE;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule

// ==== verilog/dbl_lfsr.v ====
// dbl_lfsr.v: eight-bit galois shift register with software polynomial
// assumes: same clock as the register file; polynomial stable while running
`timescale 1ns/1ps
module dbl_lfsr (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire run,
  input wire data_in,
  input wire load,
  input wire [7:0] load_value,
  input wire [7:0] polynomial,
  // state
  output reg [7:0] state_reg
);
  `include "dbl_defs.vh"

  reg [7:0] state_next;
  wire feedback;

  // serial input folds into the msb feedback; zero input gives a plain sequence
  assign feedback = state_reg[7] ^ data_in;

  // next state: bus seed load wins over shifting
  always @* begin
    state_next = state_reg;
    if (load) begin
      state_next = load_value;
    end else if (run) begin
      state_next = {state_reg[6:0], 1'b0} ^ (feedback ? polynomial : 8'h00);
    end
  end

  // shift-register state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `DBL_RST_BYTE;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// ==== verilog/dbl_block.v ====
// dbl_block.v: dead-band timer and crc/prs engine with an apb register file
// assumes: apb master on CLOCK; DATA_IN is an asynchronous pin
`timescale 1ns/1ps
module dbl_block (
  // clock and reset
  input wire CLOCK,
  input wire RESETN,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // block pins
  input wire DATA_IN,
  output reg AUX_OUT,
  output reg DEADBAND_OUT,
  output reg IRQ
);
  `include "dbl_defs.vh"

  // register file
  reg [7:0] period_poly_reg;
  reg [7:0] compare_seed_reg;
  reg [`DBL_CTL_WIDTH-1:0] control_reg;
  reg [`DBL_IRQ_WIDTH-1:0] irq_status_reg;
  reg [`DBL_IRQ_WIDTH-1:0] irq_mask_reg;
  reg [7:0] compare_seed_next;
  reg [`DBL_IRQ_WIDTH-1:0] irq_status_next;
  reg [31:0] rdata_next;
  reg slverr_next;

  // pin synchroniser
  reg data_in_meta_reg;
  reg data_in_sync_reg;

  // datapath wires
  wire [7:0] count_state;
  wire [7:0] lfsr_state;
  wire terminal_count;
  wire enabled;
  wire lfsr_checksum_mode;
  wire [1:0] cmp_type;
  wire setup;
  wire wr;
  wire rd;
  wire hit_count;
  wire hit_period;
  wire hit_seed;
  wire hit_ctl;
  wire hit_stat;
  wire hit_mask;
  wire hit_info;
  wire mapped;
  wire db_load;
  wire lfsr_load;
  wire capture;
  wire cmp_result;
  wire [7:0] active_state;
  wire [`DBL_IRQ_WIDTH-1:0] irq_event;

  // compare of two bytes by the configured type
  function cmp_bytes;
    input [1:0] kind;
    input [7:0] a;
    input [7:0] b;
    begin
      case (kind)
        `DBL_CMP_EQ: cmp_bytes = (a == b);
        `DBL_CMP_LE: cmp_bytes = (a <= b);
        `DBL_CMP_LT: cmp_bytes = (a < b);
        default: cmp_bytes = (a != b);
      endcase
    end
  endfunction

  // word address match on the low twelve bits
  function addr_is;
    input [11:0] addr;
    input [11:0] offset;
    begin
      addr_is = (addr == offset);
    end
  endfunction

  // control fields
  assign enabled = control_reg[`DBL_CTL_ENABLE];
  assign lfsr_checksum_mode = control_reg[`DBL_CTL_MODE];
  assign cmp_type = control_reg[`DBL_CTL_CMP_HI:`DBL_CTL_CMP_LO];

  // apb decode; every access completes in its first access cycle
  assign setup = PSEL && !PENABLE;
  assign wr = setup && PWRITE;
  assign rd = setup && !PWRITE;
  assign hit_count = addr_is(PADDR, `DBL_OFF_COUNT_STATE);
  assign hit_period = addr_is(PADDR, `DBL_OFF_PERIOD_POLY);
  assign hit_seed = addr_is(PADDR, `DBL_OFF_COMPARE_SEED);
  assign hit_ctl = addr_is(PADDR, `DBL_OFF_CONTROL);
  assign hit_stat = addr_is(PADDR, `DBL_OFF_IRQ_STATUS);
  assign hit_mask = addr_is(PADDR, `DBL_OFF_IRQ_MASK);
  assign hit_info = addr_is(PADDR, `DBL_OFF_STATUS);
  assign mapped = hit_count | hit_period | hit_seed | hit_ctl | hit_stat | hit_mask | hit_info;

  assign db_load = wr && hit_period && !enabled && !lfsr_checksum_mode;
  assign lfsr_load = wr && hit_seed && !enabled && lfsr_checksum_mode;
  // disabled read of hidden state captures it
  assign capture = rd && hit_count && !enabled;

  assign active_state = lfsr_checksum_mode ? lfsr_state : count_state;

  assign cmp_result = enabled && lfsr_checksum_mode &&
    cmp_bytes(cmp_type, lfsr_state, compare_seed_reg);

  // events: terminal count and rising compare
  assign irq_event = {cmp_result && !AUX_OUT, terminal_count};

  // two-flop synchroniser on the serial data pin
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      data_in_meta_reg <= 1'b0;
      data_in_sync_reg <= 1'b0;
    end else begin
      data_in_meta_reg <= DATA_IN;
      data_in_sync_reg <= data_in_meta_reg;
    end
  end

  // down counter reloads period after zero
  dbl_down_counter u_counter (
    .clk(CLOCK),
    .rst_n(RESETN),
    .run(enabled && !lfsr_checksum_mode),
    .load(db_load),
    .load_value(PWDATA[7:0]),
    .period(period_poly_reg),
    .count_reg(count_state),
    .terminal_count(terminal_count)
  );

  dbl_lfsr u_lfsr (
    .clk(CLOCK),
    .rst_n(RESETN),
    .run(enabled && lfsr_checksum_mode),
    .data_in(data_in_sync_reg),
    .load(lfsr_load),
    .load_value(PWDATA[7:0]),
    .polynomial(period_poly_reg),
    .state_reg(lfsr_state)
  );

  // seed/buffer next value; capture shares the byte with software writes
  always @* begin
    compare_seed_next = compare_seed_reg;
    if (capture) begin
      compare_seed_next = active_state;
    end else if (wr && hit_seed && lfsr_checksum_mode) begin
      compare_seed_next = PWDATA[7:0];
    end
  end

  // sticky status: an event in the clearing cycle survives
  always @* begin
    irq_status_next = irq_status_reg;
    if (wr && hit_stat) begin
      irq_status_next = irq_status_reg & ~PWDATA[`DBL_IRQ_WIDTH-1:0];
    end
    irq_status_next = irq_status_next | irq_event;
  end

  // read mux; hidden and write-only registers read zero
  always @* begin
    rdata_next = 32'h00000000;
    slverr_next = rd && !mapped;
    if (hit_seed) begin
      rdata_next = {24'h000000, compare_seed_reg};
    end else if (hit_ctl) begin
      rdata_next = {28'h0000000, control_reg};
    end else if (hit_stat) begin
      rdata_next = {30'h00000000, irq_status_reg};
    end else if (hit_mask) begin
      rdata_next = {30'h00000000, irq_mask_reg};
    end else if (hit_info) begin
      rdata_next = {22'h000000, terminal_count, AUX_OUT, active_state};
    end
    if (!rd) begin
      rdata_next = 32'h00000000;
    end
  end

  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      period_poly_reg <= `DBL_RST_BYTE;
      compare_seed_reg <= `DBL_RST_BYTE;
      control_reg <= `DBL_RST_CTL;
      irq_status_reg <= `DBL_RST_IRQ;
      irq_mask_reg <= `DBL_RST_IRQ;
    end else begin
      if (wr && hit_period) begin
        period_poly_reg <= PWDATA[7:0];
      end
      if (wr && hit_ctl) begin
        control_reg <= PWDATA[`DBL_CTL_WIDTH-1:0];
      end
      if (wr && hit_mask) begin
        irq_mask_reg <= PWDATA[`DBL_IRQ_WIDTH-1:0];
      end
      compare_seed_reg <= compare_seed_next;
      irq_status_reg <= irq_status_next;
    end
  end

  // apb answer: registered, valid in the access cycle after setup
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PRDATA <= rdata_next;
      PREADY <= setup;
      PSLVERR <= slverr_next || (wr && !mapped);
    end
  end

  // outputs from flops; dead-band output high for one clock after each terminal count
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      AUX_OUT <= 1'b0;
      DEADBAND_OUT <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      AUX_OUT <= cmp_result;
      DEADBAND_OUT <= enabled && !lfsr_checksum_mode && terminal_count;
      IRQ <= |(irq_status_next & irq_mask_reg);
    end
  end
endmodule

// ==== dv/dbl_block_props.sv ====
// dbl_block_props.sv: apb checks and pin covers for dbl_block
// assumes: bound to dbl_block, one clock domain
`timescale 1ns/1ps
module dbl_block_props (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // pins
  input wire logic AUX_OUT,
  input wire logic DEADBAND_OUT,
  input wire logic IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // setup phase and the decoded word set
  wire setup = PSEL && !PENABLE;
  wire mapped = PADDR[1:0] == 2'h0 && PADDR <= 12'h018;
  property p_ready;
    setup |=> PREADY ##1 !PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle");
  property p_cause;
    PREADY |-> $past(setup);
  endproperty
  a_cause: assert property (p_cause) else $error("ready without setup");
  property p_err;
    setup && !mapped |=> PSLVERR && PRDATA == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_ok;
    setup && mapped |=> !PSLVERR;
  endproperty
  a_ok: assert property (p_ok) else $error("mapped refused");
  property p_quiet;
    !PREADY |-> PRDATA == 32'h0 && !PSLVERR;
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus not quiet");
  property p_hidden;
    setup && !PWRITE && PADDR == 12'h000 |=> PRDATA == 32'h0;
  endproperty
  a_hidden: assert property (p_hidden) else $error("state visible");
  property p_upper;
    PREADY |-> PRDATA[31:10] == 22'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_wzero;
    setup && PWRITE |=> PRDATA == 32'h0;
  endproperty
  a_wzero: assert property (p_wzero) else $error("write returned data");
  // main scenarios reached
  c_db: cover property (DEADBAND_OUT);
  c_aux: cover property (AUX_OUT);
  c_irq: cover property (IRQ);
endmodule
bind dbl_block dbl_block_props u_props (.CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .AUX_OUT(AUX_OUT), .DEADBAND_OUT(DEADBAND_OUT), .IRQ(IRQ));

// ==== dv/tb_top.sv ====
// tb_top.sv: self-checking apb bench for dbl_block
// assumes: the block answers every setup in the next cycle
`timescale 1ns/1ps
module tb_top;
  logic CLOCK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, DATA_IN = 0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic PREADY, PSLVERR, AUX_OUT, DEADBAND_OUT, IRQ;
  logic [65:0] q[$];
  logic [65:0] e;
  logic [31:0] rs = 32'd19;
  logic [7:0] v, cnt;
  logic [7:0] pt[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05};
  int miscompares = 0, checks = 0;
  always #10 CLOCK = ~CLOCK;
  dbl_block DUT (.CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .DATA_IN(DATA_IN), .AUX_OUT(AUX_OUT), .DEADBAND_OUT(DEADBAND_OUT),
    .IRQ(IRQ));
  // xorshift source, fixed start
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0] | 8'h01;
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // one apb transfer; the note {mask, err, data} goes to the monitor
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] x, input logic [32:0] m = {33{1'b1}});
    int n;
    q.push_back({m, x});
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 9);
    if (PREADY !== 1'b1) begin
      miscompares++;
      close_out();
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask
  // high cycles of the dead-band pulse over twelve clocks
  task automatic pulses(input logic [7:0] x);
    cnt = 8'h00;
    repeat (12) begin
      @(posedge CLOCK);
      cnt += DEADBAND_OUT;
    end
    check({25'h0, cnt}, {25'h0, x});
  endtask
  // monitor: each finished access against the oldest note
  always @(posedge CLOCK) begin
    if (PSEL && PENABLE && PREADY === 1'b1) begin
      e = q.pop_front();
      check({PSLVERR, PRDATA} & e[65:33], e[32:0]);
    end
  end
  initial begin
    repeat (12) @(posedge CLOCK);
    RESETN <= 1'b1;
    @(posedge CLOCK);
    // reset values and refused places
    apb(0, 12'h00c, 0, 0);
    apb(0, 12'h010, 0, 0);
    apb(0, 12'h01c, 0, {1'b1, 32'h0});
    apb(1, 12'h020, 0, {1'b1, 32'h0});
    // disabled load, then hidden read captures into the buffer
    for (int m = 0; m < 2; m++) begin
      v = rnd();
      apb(1, 12'h00c, m << 1, 0);
      apb(1, m ? 12'h008 : 12'h004, v, 0);
      apb(0, 12'h000, 0, 0);
      apb(0, 12'h008, 0, {25'h0, v});
    end
    // dead-band length is period plus one
    foreach (pt[i]) begin
      apb(1, 12'h00c, 0, 0);
      apb(1, 12'h004, pt[i], 0);
      apb(1, 12'h00c, 1, 0);
      pulses(8'd12 / (pt[i] + 8'd1));
    end
    // enabled period write waits for a reload
    apb(1, 12'h004, 1, 0);
    repeat (8) @(posedge CLOCK);
    pulses(6);
    // terminal count event: masked, unmasked, cleared
    check({32'h0, IRQ}, 0);
    apb(0, 12'h010, 0, 1, 1);
    apb(1, 12'h014, 1, 0);
    check({32'h0, IRQ}, 1);
    apb(1, 12'h00c, 0, 0);
    apb(1, 12'h004, 5, 0);
    apb(1, 12'h010, 1, 0);
    check({32'h0, IRQ}, 0);
    // hidden count still visible on the info word after a disabled load
    apb(0, 12'h018, 0, 5);
    // no taps: state drains to zero, compared with seed then zero
    apb(1, 12'h00c, 2, 0);
    apb(1, 12'h004, 0, 0);
    for (int c = 0; c < 4; c++) begin
      v = rnd();
      apb(1, 12'h00c, 2, 0);
      apb(1, 12'h008, v, 0);
      apb(1, 12'h00c, 3 | (c << 2), 0);
      repeat (10) @(posedge CLOCK);
      check({32'h0, AUX_OUT}, {32'h0, 4'b1110 >> c} & 1);
      apb(1, 12'h008, 0, 0);
      apb(0, 12'h008, 0, 0);
      check({32'h0, AUX_OUT}, {32'h0, 4'b0011 >> c} & 1);
    end
    // rising compare left its sticky status bit
    apb(0, 12'h010, 0, 2, 2);
    close_out();
  end
endmodule
